// >>> core/mvcr_top.sv
// Interrupt-message and product-data capability register bank of one switch port.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "mvcr_map.svh"

module mvcr_top #(
  parameter bit UPSTREAM = 1'b0
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  output logic                    irq,
  input  wire logic               svc_req,
  output logic                    intx_out,
  output mvcr_pkg::mvcr_msi_wr_t  msi_wr,
  input  wire logic               msi_ack,
  output mvcr_pkg::mvcr_ee_cmd_t  ee_cmd,
  input  wire logic               ee_ack,
  input  wire logic [31:0]        ee_rdata
);
  import mvcr_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  mvcr_state_t s_reg;
  mvcr_state_t s_next;

  logic [31:0] rd_val;
  logic        wr_pd_ctrl;
  logic        ds;
  logic [1:0]  irq_set;
  logic [1:0]  irq_clr;

  assign ds = !UPSTREAM;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Registers of the other port kind read as zero, like any unmapped offset.
  always_comb begin
    rd_val = 32'h00000000;
    if (ds && hit(reg_addr, `MVCR_OFF_MSI_CTRL)) begin
      rd_val = {8'h00, `MVCR_CAP64_VAL, s_reg.msi_mme, 3'h0, s_reg.msi_en,
                `MVCR_MSI_NEXT, `MVCR_MSI_CAP_ID};
    end else if (ds && hit(reg_addr, `MVCR_OFF_MSI_ADDR)) begin
      rd_val = {s_reg.msi_addr, 2'h0};
    end else if (ds && hit(reg_addr, `MVCR_OFF_MSI_UPPER)) begin
      rd_val = s_reg.msi_upper;
    end else if (ds && hit(reg_addr, `MVCR_OFF_MSI_DATA)) begin
      rd_val = {16'h0000, s_reg.msi_data};
    end else if (!ds && hit(reg_addr, `MVCR_OFF_PD_CTRL)) begin
      rd_val = {s_reg.pd_op, 7'h00, s_reg.pd_addr, 2'h0,
                `MVCR_PD_NEXT, `MVCR_PD_CAP_ID};
    end else if (!ds && hit(reg_addr, `MVCR_OFF_PD_WORD)) begin
      rd_val = s_reg.pd_word;
    end else if (hit(reg_addr, `MVCR_OFF_VND_HDR)) begin
      rd_val = {`MVCR_VND_LEN, `MVCR_VND_NEXT, `MVCR_VND_CAP_ID};
    end else if (hit(reg_addr, `MVCR_OFF_TEST0)) begin
      rd_val = s_reg.test0;
    end else if (hit(reg_addr, `MVCR_OFF_IRQ_STAT)) begin
      rd_val = {30'h0, s_reg.irq_stat};
    end else if (hit(reg_addr, `MVCR_OFF_IRQ_MASK)) begin
      rd_val = {30'h0, s_reg.irq_mask};
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next     = s_reg;
    irq_set    = 2'h0;
    irq_clr    = 2'h0;
    wr_pd_ctrl = reg_wr && !ds && hit(reg_addr, `MVCR_OFF_PD_CTRL);

    s_next.rdata = reg_rd ? rd_val : s_reg.rdata;

    if (reg_wr) begin
      if (ds && hit(reg_addr, `MVCR_OFF_MSI_CTRL)) begin
        s_next.msi_en  = reg_wdata[`MVCR_BIT_MSI_EN];
        s_next.msi_mme = reg_wdata[22:20];
      end
      if (ds && hit(reg_addr, `MVCR_OFF_MSI_ADDR)) begin
        s_next.msi_addr = reg_wdata[31:2];
      end
      if (ds && hit(reg_addr, `MVCR_OFF_MSI_UPPER)) begin
        s_next.msi_upper = reg_wdata;
      end
      if (ds && hit(reg_addr, `MVCR_OFF_MSI_DATA)) begin
        s_next.msi_data = reg_wdata[15:0];
      end
      // Data written during a cycle would corrupt the word in flight, so it is dropped.
      if (!ds && hit(reg_addr, `MVCR_OFF_PD_WORD) && s_reg.pd_state == MVCR_PD_IDLE) begin
        s_next.pd_word = reg_wdata;
      end
      if (hit(reg_addr, `MVCR_OFF_TEST0)) begin
        s_next.test0 = reg_wdata;
      end
      if (hit(reg_addr, `MVCR_OFF_IRQ_MASK)) begin
        s_next.irq_mask = reg_wdata[1:0];
      end
    end

    // Table access sequencer.
    case (s_reg.pd_state)
      MVCR_PD_IDLE: begin
        if (wr_pd_ctrl) begin
          s_next.pd_addr  = reg_wdata[`MVCR_PD_ADDR_MSB:`MVCR_PD_ADDR_LSB];
          s_next.pd_op    = reg_wdata[`MVCR_BIT_PD_OP];
          s_next.ee_we    = reg_wdata[`MVCR_BIT_PD_OP];
          s_next.ee_req   = 1'b1;
          s_next.pd_state = MVCR_PD_BUSY;
        end
      end
      MVCR_PD_BUSY: begin
        if (ee_ack) begin
          s_next.ee_req   = 1'b0;
          s_next.pd_op    = !s_reg.pd_op;
          s_next.pd_state = MVCR_PD_IDLE;
          irq_set[`MVCR_IRQ_PD_DONE] = 1'b1;
          if (!s_reg.ee_we) begin
            s_next.pd_word = ee_rdata;
          end
        end
      end
      default: begin
        s_next.pd_state = MVCR_PD_IDLE;
        s_next.ee_req   = 1'b0;
      end
    endcase

    // Service requests on a downstream port only: message write on a rising request while messages are enabled, wired level otherwise.
    s_next.svc_prev = svc_req;
    s_next.intx     = svc_req && !s_reg.msi_en && ds;
    if (!s_reg.msi_en) begin
      s_next.msi_pend = 1'b0;
    end else if (svc_req && !s_reg.svc_prev && ds) begin
      s_next.msi_pend = 1'b1;
    end
    if (s_reg.msi_req) begin
      if (msi_ack) begin
        s_next.msi_req = 1'b0;
        irq_set[`MVCR_IRQ_MSI_SENT] = 1'b1;
      end
    end else if (s_reg.msi_pend && s_reg.msi_en) begin
      s_next.msi_req  = 1'b1;
      s_next.msi_pend = 1'b0;
    end

    // A read of status clears it, but an event in the same cycle survives.
    if (reg_rd && hit(reg_addr, `MVCR_OFF_IRQ_STAT)) begin
      irq_clr = 2'h3;
    end
    s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | irq_set;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_reg          <= '0;
      s_reg.pd_state <= MVCR_PD_IDLE;
      s_reg.test0    <= `MVCR_TEST0_RST;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata      = s_reg.rdata;
  assign irq            = s_reg.irq;
  assign intx_out       = s_reg.intx;
  assign msi_wr.req     = s_reg.msi_req;
  assign msi_wr.addr    = {(`MVCR_CAP64_VAL ? s_reg.msi_upper : 32'h00000000),
                           s_reg.msi_addr, 2'h0};
  assign msi_wr.data    = s_reg.msi_data;
  assign ee_cmd.req     = s_reg.ee_req;
  assign ee_cmd.we      = s_reg.ee_we;
  assign ee_cmd.addr    = s_reg.pd_addr;
  assign ee_cmd.wdata   = s_reg.pd_word;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence pd_start_s;
    clk_en && wr_pd_ctrl && s_reg.pd_state == MVCR_PD_IDLE;
  endsequence

  sequence pd_done_s;
    clk_en && s_reg.pd_state == MVCR_PD_BUSY && ee_ack;
  endsequence

  // The check takes a rising request only when no message is pending or in flight.
  sequence svc_rise_s;
    clk_en && ds && s_reg.msi_en && svc_req && !s_reg.svc_prev && !s_reg.msi_pend && !s_reg.msi_req;
  endsequence

  a_msi_gated_off: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !s_reg.msi_en |=> !msi_wr.req || $past(msi_wr.req))
    else $error("message request raised while disabled");

  a_intx_off_msi: assert property (@(posedge clk) disable iff (!rst_sync_n)
    s_reg.msi_en && $past(s_reg.msi_en) |-> !intx_out)
    else $error("wired interrupt driven while messages enabled");

  a_msi_rise_req: assert property (@(posedge clk) disable iff (!rst_sync_n)
    svc_rise_s ##1 (clk_en && s_reg.msi_en) |=> msi_wr.req)
    else $error("message request missing after service request");

  a_msi_req_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
    msi_wr.req && !msi_ack |=> msi_wr.req)
    else $error("message request dropped before acceptance");

  a_intx_follow: assert property (@(posedge clk) disable iff (!rst_sync_n)
    clk_en && ds && !s_reg.msi_en |=> intx_out == $past(svc_req))
    else $error("wired interrupt does not follow the request");

  a_up_quiet: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !ds |-> !msi_wr.req && !intx_out)
    else $error("upstream port signalled an interrupt");

  a_cap_flags: assert property (@(posedge clk) disable iff (!rst_sync_n)
    clk_en && reg_rd && ds && hit(reg_addr, `MVCR_OFF_MSI_CTRL)
      |=> reg_rdata[`MVCR_BIT_CAP64] && reg_rdata[7:0] == 8'h05)
    else $error("message control header wrong");

  a_msi_ctrl_rsvd: assert property (@(posedge clk) disable iff (!rst_sync_n)
    clk_en && reg_rd && ds && hit(reg_addr, `MVCR_OFF_MSI_CTRL)
      |=> reg_rdata[31:24] == 8'h00 && reg_rdata[19:17] == 3'h0 && reg_rdata[15:8] == `MVCR_MSI_NEXT)
    else $error("message control reserved bits or pointer wrong");

  a_addr_low_zero: assert property (@(posedge clk) disable iff (!rst_sync_n)
    clk_en && reg_rd && ds && hit(reg_addr, `MVCR_OFF_MSI_ADDR) |=> reg_rdata[1:0] == 2'h0)
    else $error("message address low bits not zero");

  a_data_high_zero: assert property (@(posedge clk) disable iff (!rst_sync_n)
    clk_en && reg_rd && ds && hit(reg_addr, `MVCR_OFF_MSI_DATA) |=> reg_rdata[31:16] == 16'h0000)
    else $error("message data upper half not zero");

  a_msi_addr_out: assert property (@(posedge clk) disable iff (!rst_sync_n)
    msi_wr.addr[1:0] == 2'h0 && msi_wr.addr[63:32] == s_reg.msi_upper)
    else $error("message address not aligned or upper half lost");

  a_pd_header: assert property (@(posedge clk) disable iff (!rst_sync_n)
    clk_en && reg_rd && !ds && hit(reg_addr, `MVCR_OFF_PD_CTRL)
      |=> reg_rdata[15:0] == 16'h6403 && reg_rdata[30:24] == 7'h00 && reg_rdata[17:16] == 2'h0)
    else $error("product-data header or reserved bits wrong");

  a_pd_read_flag: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pd_start_s and !reg_wdata[`MVCR_BIT_PD_OP]
      |=> ee_cmd.req && !ee_cmd.we && !s_reg.pd_op
          && ee_cmd.addr == $past(reg_wdata[23:18]))
    else $error("read cycle did not start correctly");

  a_pd_write_start: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pd_start_s and reg_wdata[`MVCR_BIT_PD_OP]
      |=> ee_cmd.req && ee_cmd.we && s_reg.pd_op && ee_cmd.wdata == $past(s_reg.pd_word))
    else $error("write cycle did not start correctly");

  a_pd_cmd_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
    s_reg.pd_state == MVCR_PD_BUSY && !ee_ack
      |=> ee_cmd.req && $stable(ee_cmd.addr) && $stable(ee_cmd.we) && $stable(ee_cmd.wdata))
    else $error("storage command changed during cycle");

  a_pd_flip_done: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pd_done_s |=> s_reg.pd_op == !$past(s_reg.pd_op) && !ee_cmd.req)
    else $error("operation flag not toggled at cycle end");

  a_pd_flag_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
    s_reg.pd_state == MVCR_PD_BUSY && !ee_ack |=> $stable(s_reg.pd_op))
    else $error("operation flag moved during cycle");

  a_pd_capture: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pd_done_s and !s_reg.ee_we |=> s_reg.pd_word == $past(ee_rdata))
    else $error("fetched word not captured");

  a_pd_write_keep: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pd_done_s and s_reg.ee_we |=> $stable(s_reg.pd_word))
    else $error("data register changed by a write cycle");

  a_vnd_header: assert property (@(posedge clk) disable iff (!rst_sync_n)
    clk_en && reg_rd && hit(reg_addr, `MVCR_OFF_VND_HDR)
      |=> reg_rdata == 32'h0034b009)
    else $error("vendor header wrong");

  a_irq_sticky: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pd_done_s |=> s_reg.irq_stat[`MVCR_IRQ_PD_DONE])
    else $error("completion event lost");

  a_stat_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
    clk_en && reg_rd && hit(reg_addr, `MVCR_OFF_IRQ_STAT) && !ee_ack && !msi_ack |=> s_reg.irq_stat == 2'h0)
    else $error("status not cleared by its read");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_sync_n)
    irq == |(s_reg.irq_stat & s_reg.irq_mask))
    else $error("interrupt level disagrees with status and mask");

  a_clk_freeze: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !clk_en |=> $stable(s_reg))
    else $error("state moved while the clock enable was low");

endmodule : mvcr_top

// >>> inc/mvcr_map.svh
// Offsets, field positions, reset values and constants of the capability register bank.
`ifndef MVCR_MAP_SVH
`define MVCR_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MVCR_OFF_MSI_CTRL   8'h4c
`define MVCR_OFF_MSI_ADDR   8'h50
`define MVCR_OFF_MSI_UPPER  8'h54
`define MVCR_OFF_MSI_DATA   8'h58
`define MVCR_OFF_PD_CTRL    8'h5c
`define MVCR_OFF_PD_WORD    8'h60
`define MVCR_OFF_VND_HDR    8'h64
`define MVCR_OFF_TEST0      8'h68
`define MVCR_OFF_IRQ_STAT   8'h80
`define MVCR_OFF_IRQ_MASK   8'h84

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MVCR_BIT_MSI_EN     16
`define MVCR_BIT_CAP64      23
`define MVCR_PD_ADDR_LSB    18
`define MVCR_PD_ADDR_MSB    23
`define MVCR_BIT_PD_OP      31
`define MVCR_IRQ_PD_DONE    0
`define MVCR_IRQ_MSI_SENT   1

// ----------------------------------------
// Fixed values and reset values
// ----------------------------------------
`define MVCR_MSI_CAP_ID     8'h05
`define MVCR_MSI_NEXT       8'h64
`define MVCR_PD_CAP_ID      8'h03
`define MVCR_PD_NEXT        8'h64
`define MVCR_VND_CAP_ID     8'h09
`define MVCR_VND_NEXT       8'hb0
`define MVCR_VND_LEN        16'h0034
`define MVCR_TEST0_RST      32'h04001060
`define MVCR_CAP64_VAL      1'b1

`endif

// >>> inc/mvcr_pkg.sv
// Types shared by the capability register bank.
package mvcr_pkg;

  typedef enum logic [0:0] {
    MVCR_PD_IDLE = 1'b0,
    MVCR_PD_BUSY = 1'b1
  } mvcr_pd_state_t;

  typedef struct packed {
    logic [5:0]  addr;
    logic        we;
    logic        req;
    logic [31:0] wdata;
  } mvcr_ee_cmd_t;

  typedef struct packed {
    logic        req;
    logic [63:0] addr;
    logic [15:0] data;
  } mvcr_msi_wr_t;

  typedef struct packed {
    logic           msi_en;
    logic [2:0]     msi_mme;
    logic [29:0]    msi_addr;
    logic [31:0]    msi_upper;
    logic [15:0]    msi_data;
    logic [5:0]     pd_addr;
    logic           pd_op;
    logic [31:0]    pd_word;
    logic [31:0]    test0;
    logic [1:0]     irq_stat;
    logic [1:0]     irq_mask;
    mvcr_pd_state_t pd_state;
    logic [31:0]    rdata;
    logic           irq;
    logic           ee_req;
    logic           ee_we;
    logic           msi_req;
    logic           svc_prev;
    logic           msi_pend;
    logic           intx;
  } mvcr_state_t;

endpackage : mvcr_pkg

// >>> tb/mvcr_ee_model.sv
// Behavioural table storage and message sink facing the capability register bank.
`timescale 1ns/1ps
module mvcr_ee_model (
  input  wire logic                   clk,
  input  wire logic [3:0]             lat,
  input  wire mvcr_pkg::mvcr_ee_cmd_t ee_cmd,
  output logic                        ee_ack,
  output logic [31:0]                 ee_rdata,
  input  wire mvcr_pkg::mvcr_msi_wr_t msi_wr,
  output logic                        msi_ack
);
  import mvcr_pkg::*;
  logic [31:0] mem [64];
  logic [3:0]  ecnt = 4'h0;
  logic [3:0]  mcnt = 4'h0;
  logic        edone = 1'b0;
  logic        mdone = 1'b0;
  logic        eack_q = 1'b0;
  logic        mack_q = 1'b0;
  logic [31:0] erd_q = 32'h0;

  assign ee_ack   = eack_q;
  assign msi_ack  = mack_q;
  assign ee_rdata = erd_q;

  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'h5a5a0000 + 32'(i);
    end
  end

  // ----------------------------------------
  // Storage cycles and message acceptance
  // ----------------------------------------
  // Read data toggles outside the acknowledge so a stale word never passes for a fresh one.
  // The request may stand one cycle past the acknowledge, so each request is answered once.
  always @(posedge clk) begin
    eack_q <= 1'b0;
    mack_q <= 1'b0;
    erd_q <= ~erd_q;
    if (!ee_cmd.req) begin
      ecnt <= 4'h0;
      edone <= 1'b0;
    end else if (!edone && ecnt == lat) begin
      eack_q <= 1'b1;
      edone <= 1'b1;
      if (ee_cmd.we)
        mem[ee_cmd.addr] <= ee_cmd.wdata;
      else
        erd_q <= mem[ee_cmd.addr];
    end else if (!edone) begin
      ecnt <= ecnt + 4'h1;
    end
    if (!msi_wr.req) begin
      mcnt <= 4'h0;
      mdone <= 1'b0;
    end else if (!mdone && mcnt == lat) begin
      mack_q <= 1'b1;
      mdone <= 1'b1;
    end else if (!mdone) begin
      mcnt <= mcnt + 4'h1;
    end
  end
endmodule : mvcr_ee_model

// >>> tb/tb.sv
// Self-checking bench for the capability register bank, one instance of each port kind.
`timescale 1ns/1ps
module tb;
  import mvcr_pkg::*;
  logic         clk, rst_n, reg_wr, reg_rd, svc_req, ce;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, rdata_dn, rdata_up, erd_dn, erd_up;
  logic         irq_dn, irq_up, intx_dn, intx_up, mack_dn, mack_up, eack_dn, eack_up;
  mvcr_msi_wr_t msi_dn, msi_up;
  mvcr_ee_cmd_t ee_dn, ee_up;
  logic [3:0]   lat;
  int           err_count, n_checks, cycles;

  mvcr_top #(.UPSTREAM(1'b0)) mvcr_top_i (.clk(clk), .rst_n(rst_n), .clk_en(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_dn), .irq(irq_dn), .svc_req(svc_req),
    .intx_out(intx_dn), .msi_wr(msi_dn), .msi_ack(mack_dn), .ee_cmd(ee_dn), .ee_ack(eack_dn), .ee_rdata(erd_dn));
  mvcr_top #(.UPSTREAM(1'b1)) mvcr_top_up_i (.clk(clk), .rst_n(rst_n), .clk_en(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_up), .irq(irq_up), .svc_req(svc_req),
    .intx_out(intx_up), .msi_wr(msi_up), .msi_ack(mack_up), .ee_cmd(ee_up), .ee_ack(eack_up), .ee_rdata(erd_up));
  mvcr_ee_model mvcr_ee_model_i (.clk(clk), .lat(lat), .ee_cmd(ee_dn), .ee_ack(eack_dn), .ee_rdata(erd_dn),
    .msi_wr(msi_dn), .msi_ack(mack_dn));
  mvcr_ee_model mvcr_ee_model_up_i (.clk(clk), .lat(lat), .ee_cmd(ee_up), .ee_ack(eack_up), .ee_rdata(erd_up),
    .msi_wr(msi_up), .msi_ack(mack_up));

  // ----------------------------------------
  // Bus helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data appear at the edge that samples the strobe and hold until the next read, so they are taken just past that edge.
  task automatic rd(input bit up, input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = up ? rdata_up : rdata_dn;
  endtask : rd

  task automatic rc(input bit up, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(up, a, v);
    chk(v, exp);
  endtask : rc

  // Polls the upstream control word until its flag matches, then checks the whole word.
  task automatic poll(input logic [31:0] exp);
    logic [31:0] v;
    int          k;
    k = 0;
    rd(1'b1, 8'h5c, v);
    while (k < 40 && v[31] !== exp[31]) begin
      rd(1'b1, 8'h5c, v);
      k++;
    end
    chk(v, exp);
  endtask : poll

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_map;
    rc(1'b0, 8'h4c, 32'h00806405);
    rc(1'b0, 8'h50, 32'h0);
    rc(1'b0, 8'h54, 32'h0);
    rc(1'b0, 8'h58, 32'h0);
    rc(1'b0, 8'h64, 32'h0034b009);
    rc(1'b0, 8'h68, 32'h04001060);
    rc(1'b0, 8'h5c, 32'h0);
    rc(1'b1, 8'h5c, 32'h00006403);
    rc(1'b1, 8'h60, 32'h0);
    rc(1'b1, 8'h64, 32'h0034b009);
    rc(1'b1, 8'h70, 32'h0);
  endtask : t_reset_map

  task automatic t_reg_access;
    wr(8'h4c, 32'hffffffff);
    rc(1'b0, 8'h4c, 32'h00f16405);
    wr(8'h50, 32'hffffffff);
    rc(1'b0, 8'h50, 32'hfffffffc);
    wr(8'h54, 32'hffffffff);
    rc(1'b0, 8'h54, 32'hffffffff);
    wr(8'h58, 32'hffffffff);
    rc(1'b0, 8'h58, 32'h0000ffff);
    wr(8'h64, 32'h0);
    rc(1'b1, 8'h64, 32'h0034b009);
    wr(8'h68, 32'h12345678);
    rc(1'b0, 8'h68, 32'h12345678);
    wr(8'h4c, 32'h0);
  endtask : t_reg_access

  task automatic t_msi_off;
    @(posedge clk);
    svc_req <= 1'b1;
    repeat (6) begin
      @(posedge clk);
      #1;
      chk({31'h0, msi_dn.req}, 32'h0);
    end
    chk({31'h0, intx_dn}, 32'h1);
    chk({31'h0, intx_up}, 32'h0);
    chk({31'h0, msi_up.req}, 32'h0);
    @(posedge clk);
    svc_req <= 1'b0;
  endtask : t_msi_off

  task automatic t_msi_send;
    int k;
    wr(8'h50, 32'h1234567b);
    wr(8'h54, 32'hcafe0001);
    wr(8'h58, 32'h0000beef);
    wr(8'h84, 32'h00000002);
    wr(8'h4c, 32'h00010000);
    @(posedge clk);
    svc_req <= 1'b1;
    k = 0;
    while (msi_dn.req !== 1'b1 && k < 4) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({31'h0, msi_dn.req}, 32'h1);
    chk(msi_dn.addr[31:0], 32'h12345678);
    chk(msi_dn.addr[63:32], 32'hcafe0001);
    chk({16'h0, msi_dn.data}, 32'h0000beef);
    chk({31'h0, intx_dn}, 32'h0);
    k = 0;
    while (irq_dn !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({31'h0, irq_dn}, 32'h1);
    rc(1'b0, 8'h80, 32'h00000002);
    @(posedge clk);
    #1;
    chk({31'h0, irq_dn}, 32'h0);
    @(posedge clk);
    svc_req <= 1'b0;
    wr(8'h4c, 32'h0);
  endtask : t_msi_send

  // A write to TEST0 made while the clock enable is low must leave TEST0 of both instances untouched.
  task automatic t_clk_hold;
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h68, 32'h0000abcd);
    @(posedge clk);
    ce <= 1'b1;
    rc(1'b0, 8'h68, 32'h12345678);
    rc(1'b1, 8'h68, 32'h12345678);
  endtask : t_clk_hold

  task automatic t_table;
    wr(8'h84, 32'h00000001);
    wr(8'h60, 32'h13579bdf);
    wr(8'h5c, 32'h80140000);
    #1;
    chk({26'h0, ee_up.addr}, 32'h5);
    rc(1'b1, 8'h5c, 32'h80146403);
    wr(8'h60, 32'h2468ace0);
    chk({31'h0, ee_dn.req}, 32'h0);
    poll(32'h00146403);
    chk(mvcr_ee_model_up_i.mem[5], 32'h13579bdf);
    rc(1'b1, 8'h60, 32'h13579bdf);
    wr(8'h5c, 32'h00180000);
    rc(1'b1, 8'h5c, 32'h00186403);
    poll(32'h80186403);
    rc(1'b1, 8'h60, 32'h5a5a0006);
    chk({31'h0, irq_up}, 32'h1);
    rc(1'b1, 8'h80, 32'h00000001);
  endtask : t_table

  task automatic complete_run;
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    svc_req = 1'b0;
    ce = 1'b1;
    lat = 4'h8;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_map();
    t_reg_access();
    t_clk_hold();
    t_msi_off();
    t_msi_send();
    t_table();
    complete_run();
  end
endmodule : tb
